// ==== hw/quadrature_actual_value.sv ====
// Quadrature encoder actual value generator with zero offset handling and an APB register file.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////////////////////////
module quadrature_actual_value
  import qav_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Encoder channels.
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  // Zone range inputs from the comparison logic.
  input  wire logic        outer_zone_in,
  input  wire logic        switch_zone_in,
  input  wire logic        target_zone_in,
  input  wire logic        travel_dir_in,
  input  wire logic        target_select,
  input  wire logic        cycle_tick,
  // Status and interrupt outputs.
  output logic             outputs_enable,
  output logic             outer_zone_flag,
  output logic             switch_zone_flag,
  output logic             target_zone_flag,
  output logic             travel_direction_flag,
  output logic             irq
);

  typedef enum logic [1:0] {IDLE_ST = 2'b00, APPLY_ST = 2'b01, LOAD_ST = 2'b11} op_type;

  logic        [31:0] ctrl_r;
  logic        [31:0] zero_offset_value_r;
  logic        [31:0] rotary_final_r;
  logic signed [31:0] count_r;
  logic signed [31:0] actual_r;
  logic signed [31:0] rel_old_r;
  logic               overrange_flag_r;
  logic               over_seen_r;
  logic               sync_r;
  logic               valid_r;
  logic               overrange_irq_bit_r;
  logic               irq_mask_r;
  logic        [1:0]  ab_r;
  logic               ab_init_r;
  op_type             op_r;
  logic               op_load_r;

  logic               wr_en;
  logic               rd_en;
  logic signed [31:0] offset_bin;
  logic        [2:0]  mult;
  logic signed [31:0] step;
  logic               in_range;
  logic               over_enter;
  logic               status_rd_clr;
  logic               irq_rd_clr;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mult  = ctrl_r[CTRL_MULT_LSB +: 3];

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Offset decoding from binary or sign nibble plus BCD digits.
  always_comb begin
    logic signed [31:0] mag;
    mag = '0;
    if (ctrl_r[CTRL_BCD_BIT]) begin
      for (int i = 6; i >= 0; i--) begin
        mag = 32'(mag * 10 + 32'(zero_offset_value_r[4*i +: 4]));
      end
      offset_bin = (zero_offset_value_r[31:28] == 4'hf) ? -mag : mag;
    end else begin
      offset_bin = $signed({{8{zero_offset_value_r[23]}}, zero_offset_value_r[23:0]});
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Quadrature decoding with resolution multiplier.
  always_comb begin
    logic fwd;
    logic bwd;
    fwd  = 1'b0;
    bwd  = 1'b0;
    step = '0;
    // Gray sequence 00,01,11,10 forward means B leads A.
    if (ab_init_r) begin
      case ({ab_r, enc_a, enc_b})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: fwd = 1'b1;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: bwd = 1'b1;
        default: begin
          fwd = 1'b0;
          bwd = 1'b0;
        end
      endcase
    end
    case (mult)
      MULT_ONE: begin
        if (fwd && ab_r == 2'b01 && {enc_a, enc_b} == 2'b11) begin
          step = 32'sd1;
        end else if (bwd && ab_r == 2'b11 && {enc_a, enc_b} == 2'b01) begin
          step = -32'sd1;
        end
      end
      MULT_TWO: begin
        if (ab_r[1] != enc_a) begin
          step = fwd ? 32'sd1 : (bwd ? -32'sd1 : 32'sd0);
        end
      end
      default: begin
        step = fwd ? 32'sd1 : (bwd ? -32'sd1 : 32'sd0);
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ab_r      <= 2'b00;
      ab_init_r <= 1'b0;
    end else begin
      ab_r      <= {enc_a, enc_b};
      ab_init_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Internal count with offset operations.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_r   <= '0;
      rel_old_r <= '0;
    end else if (op_r == LOAD_ST) begin
      if (ctrl_r[CTRL_ROTARY_BIT] && offset_bin < 0) begin
        count_r <= $signed(rotary_final_r) + offset_bin + step;
      end else begin
        count_r <= offset_bin + step;
      end
      rel_old_r <= ctrl_r[CTRL_ADD_BIT] ? 32'sd0 : offset_bin;
    end else if (op_r == APPLY_ST) begin
      if (ctrl_r[CTRL_ADD_BIT]) begin
        count_r   <= count_r + offset_bin + step;
        rel_old_r <= '0;
      end else begin
        count_r   <= count_r + offset_bin - rel_old_r + step;
        rel_old_r <= offset_bin;
      end
    end else begin
      count_r <= count_r + step;
    end
  end

  // Offset operation sequencer.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      op_r      <= IDLE_ST;
      op_load_r <= 1'b0;
    end else if (wr_en && paddr == OFS_COMMAND && op_r == IDLE_ST) begin
      if (pwdata[CMD_CONFIG_BIT] || pwdata[CMD_SYNC_BIT]) begin
        op_r <= LOAD_ST;
      end else if (pwdata[CMD_APPLY_BIT]) begin
        op_r <= APPLY_ST;
      end
      op_load_r <= pwdata[CMD_SYNC_BIT];
    end else begin
      op_r      <= IDLE_ST;
      op_load_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Actual value snapshot and overrange handling.
  assign in_range   = (actual_r >= -RANGE_LIMIT) && (actual_r <= RANGE_LIMIT);
  assign over_enter = !in_range && !over_seen_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      actual_r <= '0;
    end else if (cycle_tick) begin
      actual_r <= count_r;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      over_seen_r <= 1'b0;
    end else begin
      over_seen_r <= !in_range;
    end
  end

  assign status_rd_clr = rd_en && paddr == OFS_STATUS && overrange_flag_r;
  assign irq_rd_clr    = rd_en && paddr == OFS_IRQ_STAT && overrange_irq_bit_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overrange_flag_r <= 1'b0;
    end else if (over_enter) begin
      overrange_flag_r <= 1'b1;
    end else if (status_rd_clr || irq_rd_clr) begin
      overrange_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overrange_irq_bit_r <= 1'b0;
    end else if (over_enter && ctrl_r[CTRL_IRQSEL_BIT]) begin
      overrange_irq_bit_r <= 1'b1;
    end else if (rd_en && paddr == OFS_IRQ_STAT) begin
      overrange_irq_bit_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_r  <= 1'b0;
      valid_r <= 1'b0;
    end else if (over_enter) begin
      sync_r  <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      if (op_load_r) begin
        sync_r <= 1'b1;
      end
      if (target_select) begin
        valid_r <= 1'b1;
      end
    end
  end

  // Zone and direction flags are forced high while the actual value is out of range.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outer_zone_flag       <= 1'b1;
      switch_zone_flag      <= 1'b1;
      target_zone_flag      <= 1'b1;
      travel_direction_flag <= 1'b1;
      outputs_enable        <= 1'b0;
    end else if (over_enter || !in_range) begin
      outer_zone_flag       <= 1'b1;
      switch_zone_flag      <= 1'b1;
      target_zone_flag      <= 1'b1;
      travel_direction_flag <= 1'b1;
      outputs_enable        <= 1'b0;
    end else begin
      outer_zone_flag       <= !outer_zone_in;
      switch_zone_flag      <= !switch_zone_in;
      target_zone_flag      <= !target_zone_in;
      travel_direction_flag <= travel_dir_in;
      outputs_enable        <= valid_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // APB register file.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r              <= CTRL_RESET;
      zero_offset_value_r <= '0;
      rotary_final_r      <= ROTARY_RESET;
      irq_mask_r          <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL:     ctrl_r <= pwdata;
        OFS_OFFSET:   zero_offset_value_r <= pwdata;
        OFS_ROTARY:   rotary_final_r <= pwdata;
        OFS_IRQ_MASK: irq_mask_r <= pwdata[ST_OVER_BIT];
        default: begin
          irq_mask_r <= irq_mask_r;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr)
          OFS_CTRL:     prdata <= ctrl_r;
          OFS_OFFSET:   prdata <= zero_offset_value_r;
          OFS_ACTUAL:   prdata <= actual_r;
          OFS_STATUS:   prdata <= {24'h000000, outputs_enable, valid_r, travel_direction_flag, target_zone_flag,
                                   switch_zone_flag, outer_zone_flag, sync_r, overrange_flag_r};
          OFS_IRQ_STAT: prdata <= {31'h00000000, overrange_irq_bit_r};
          OFS_IRQ_MASK: prdata <= {31'h00000000, irq_mask_r};
          OFS_ROTARY:   prdata <= rotary_final_r;
          OFS_COMMAND:  prdata <= '0;
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= overrange_irq_bit_r && irq_mask_r;
    end
  end

endmodule // quadrature_actual_value
`default_nettype wire

// ==== inc/qav_pkg.sv ====
// Package with register map, field positions, reset values and range constants of the actual value block.
`default_nettype none
package qav_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_OFFSET   = 8'h04;
  localparam logic [7:0] OFS_ACTUAL   = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_ROTARY   = 8'h18;
  localparam logic [7:0] OFS_COMMAND  = 8'h1c;
  // Control register fields.
  localparam int CTRL_ADD_BIT    = 0;
  localparam int CTRL_BCD_BIT    = 1;
  localparam int CTRL_ROTARY_BIT = 2;
  localparam int CTRL_IRQSEL_BIT = 3;
  localparam int CTRL_MULT_LSB   = 4;
  // Command register fields (write one to act).
  localparam int CMD_APPLY_BIT  = 0;
  localparam int CMD_CONFIG_BIT = 1;
  localparam int CMD_SYNC_BIT   = 2;
  // Status register fields.
  localparam int ST_OVER_BIT   = 0;
  localparam int ST_SYNC_BIT   = 1;
  localparam int ST_OUTER_BIT  = 2;
  localparam int ST_SWITCH_BIT = 3;
  localparam int ST_TARGET_BIT = 4;
  localparam int ST_DIR_BIT    = 5;
  localparam int ST_VALID_BIT  = 6;
  localparam int ST_OUTEN_BIT  = 7;
  // Resolution multiplier codes.
  localparam logic [2:0] MULT_ONE  = 3'h1;
  localparam logic [2:0] MULT_TWO  = 3'h2;
  localparam logic [2:0] MULT_FOUR = 3'h4;
  // Reset values.
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0010;
  localparam logic [31:0] ROTARY_RESET = 32'h0000_2710;
  // Defined actual value range limit.
  localparam logic signed [31:0] RANGE_LIMIT = 32'sd9999999;
endpackage
`default_nettype wire

// ==== testbench/qav_monitor.sv ====
// Checker of the actual value block's port behaviour.
`timescale 1ns/10ps
`default_nettype none
module qav_monitor (
  // Clock, reset and bus.
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Zones and status.
  input wire logic outer_zone_in,
  input wire logic switch_zone_in,
  input wire logic target_zone_in,
  input wire logic outer_zone_flag,
  input wire logic switch_zone_flag,
  input wire logic target_zone_flag,
  input wire logic travel_direction_flag,
  input wire logic outputs_enable,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  AST_ANSWER: assert property (setup_s |=> answer_s)
    else $error("bus answer missing after setup");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_OUTER_IN: assert property (!outer_zone_flag |-> $past(outer_zone_in))
    else $error("outer zone flag low while outside");
  AST_SWITCH_IN: assert property (!switch_zone_flag |-> $past(switch_zone_in))
    else $error("switch zone flag low while outside");
  AST_TARGET_IN: assert property (!target_zone_flag |-> $past(target_zone_in))
    else $error("target zone flag low while outside");
  AST_OUTER_OUT: assert property ($fell(outer_zone_in) |=> outer_zone_flag)
    else $error("outer zone flag not raised on leaving");
  AST_OVER_IRQ: assert property ($rose(irq) |-> !outputs_enable && travel_direction_flag)
    else $error("overrange interrupt with outputs still on");
endmodule // qav_monitor
bind quadrature_actual_value qav_monitor qav_monitor_i (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .outer_zone_in(outer_zone_in), .switch_zone_in(switch_zone_in), .target_zone_in(target_zone_in),
  .outer_zone_flag(outer_zone_flag), .switch_zone_flag(switch_zone_flag), .target_zone_flag(target_zone_flag),
  .travel_direction_flag(travel_direction_flag), .outputs_enable(outputs_enable), .irq(irq)
);
`default_nettype wire

// ==== testbench/qav_encoder_model.sv ====
// Behavioural incremental quadrature encoder.
`timescale 1ns/10ps
`default_nettype none
module qav_encoder_model (
  // Clock.
  input  wire logic clock,
  // Encoder channels.
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] phase_r = 2'h0;
  int         left_r = 0;
  int         gap_r = 0;
  int         wait_r = 0;
  bit         down_r = 1'b0;
  // Queues a run of steps; a gap slows the encoder down.
  task automatic move(input int n, input bit down, input int gap);
    left_r = n;
    down_r = down;
    gap_r = gap;
    wait_r = gap;
  endtask
  // B leads on up runs, A leads on down runs.
  always @(posedge clock) begin
    if (left_r > 0 && wait_r > 0) begin
      wait_r--;
    end else if (left_r > 0) begin
      phase_r <= down_r ? phase_r - 2'h1 : phase_r + 2'h1;
      left_r--;
      wait_r = gap_r;
    end
  end
  assign enc_a = phase_r[1];
  assign enc_b = phase_r[1] ^ phase_r[0];
endmodule // qav_encoder_model
`default_nettype wire

// ==== testbench/quadrature_actual_value_bench.sv ====
// Self-checking bench of the quadrature actual value block.
`timescale 1ns/10ps
`default_nettype none
module quadrature_actual_value_bench;
  import qav_pkg::*;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        enc_a, enc_b, cycle_tick, target_select, travel_dir_in, irq;
  logic        outer_zone_in, switch_zone_in, target_zone_in, outputs_enable;
  logic        outer_zone_flag, switch_zone_flag, target_zone_flag, travel_direction_flag;
  int          fail_count, check_count;
  quadrature_actual_value quadrature_actual_value_i (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
    .outer_zone_in(outer_zone_in), .switch_zone_in(switch_zone_in), .target_zone_in(target_zone_in),
    .travel_dir_in(travel_dir_in), .target_select(target_select), .cycle_tick(cycle_tick),
    .outputs_enable(outputs_enable), .outer_zone_flag(outer_zone_flag), .switch_zone_flag(switch_zone_flag),
    .target_zone_flag(target_zone_flag), .travel_direction_flag(travel_direction_flag), .irq(irq)
  );
  qav_encoder_model qav_encoder_model_i (
    .clock(clock), .enc_a(enc_a), .enc_b(enc_b)
  );
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("mismatches %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      conclude;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic tk;
    repeat (2) @(posedge clock);
    cycle_tick <= 1'b1;
    @(posedge clock);
    cycle_tick <= 1'b0;
  endtask
  task automatic mv(input int n, input bit dn, input int g);
    qav_encoder_model_i.move(n, dn, g);
    repeat (n * (g + 1) + 3) @(posedge clock);
  endtask
  task automatic ld(input logic [31:0] ctl, input logic [31:0] ofs, input logic [31:0] cmd);
    apb(1'b1, OFS_CTRL, ctl);
    apb(1'b1, OFS_OFFSET, ofs);
    apb(1'b1, OFS_COMMAND, cmd);
    tk;
  endtask
  task automatic ap(input logic add, input logic [31:0] v, input logic [31:0] x);
    ld(32'h40 | 32'(add), v, 32'h1);
    rdc(OFS_ACTUAL, x);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(OFS_CTRL, CTRL_RESET);
    rdc(OFS_ROTARY, ROTARY_RESET);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h24, 32'h1);
    chk(32'(e), 32'h1);
  endtask
  task automatic t_count;
    logic [2:0] m [3];
    m = '{MULT_ONE, MULT_TWO, MULT_FOUR};
    for (int i = 0; i < 3; i++) begin
      ld(32'(m[i]) << CTRL_MULT_LSB, 32'h0, 32'h2);
      rdc(OFS_ACTUAL, 32'h0);
      mv(8, 1'b0, i);
      rdc(OFS_ACTUAL, 32'h0);
      tk;
      rdc(OFS_ACTUAL, 32'(m[i]) * 2);
      mv(4, 1'b1, 0);
      tk;
      rdc(OFS_ACTUAL, 32'(m[i]));
    end
  endtask
  task automatic t_offset;
    ld(32'h40, 32'h0, 32'h2);
    ap(1'b0, 32'd1000, 32'd1000);
    ap(1'b0, 32'd500, 32'd500);
    ap(1'b1, 32'd300, 32'd800);
    ap(1'b0, 32'd200, 32'd1000);
  endtask
  task automatic t_sync;
    apb(1'b1, OFS_ROTARY, 32'd10000);
    ld(32'h44, 32'hffff_f830, 32'h4);
    rdc(OFS_ACTUAL, 32'd8000);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(q[ST_SYNC_BIT]), 32'h1);
    ld(32'h42, 32'hf000_1234, 32'h2);
    rdc(OFS_ACTUAL, -32'sd1234);
  endtask
  task automatic t_over;
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    ld(32'h4a, 32'h0999_9999, 32'h4);
    target_select <= 1'b1;
    @(posedge clock);
    target_select <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'({outputs_enable, outer_zone_flag}), 32'h2);
    mv(4, 1'b0, 0);
    tk;
    rdc(OFS_ACTUAL, 32'd10000003);
    chk(32'({irq, outputs_enable, outer_zone_flag, switch_zone_flag, target_zone_flag,
             travel_direction_flag}), 32'h2f);
    rdc(OFS_STATUS, 32'h3d);
    rdc(OFS_STATUS, 32'h3c);
    rdc(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    mv(8, 1'b1, 0);
    tk;
    apb(1'b1, OFS_CTRL, 32'h42);
    mv(8, 1'b0, 2);
    tk;
    rdc(OFS_STATUS, 32'h3d);
    chk(32'(irq), 32'h0);
    rdc(OFS_IRQ_STAT, 32'h0);
    {outer_zone_in, switch_zone_in, target_zone_in} <= 3'h0;
    repeat (2) @(posedge clock);
    chk(32'(outer_zone_flag), 32'h1);
    mv(8, 1'b1, 0);
    tk;
    repeat (2) @(posedge clock);
    chk(32'({outer_zone_flag, switch_zone_flag, target_zone_flag}), 32'h7);
    {outer_zone_in, switch_zone_in, target_zone_in} <= 3'h7;
    repeat (2) @(posedge clock);
    chk(32'({outer_zone_flag, switch_zone_flag, target_zone_flag, travel_direction_flag}), 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, cycle_tick, target_select, travel_dir_in} = 6'h0;
    {outer_zone_in, switch_zone_in, target_zone_in} = 3'h7;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_count;
    t_offset;
    t_sync;
    t_over;
    conclude;
  end
endmodule // quadrature_actual_value_bench
`default_nettype wire
